// ---- hdl/sse_spi_status.sv ----
// spi command interpreter with reset, watchdog and diagnostic encoders
//
// Functional notes
// - threshold code 00 is invalid; previously selected threshold is kept
// - codes 01, 10, 11 select reset levels one, two, three
// - five-bit watchdog period field, default code 01111 (256 ms)
// - codes 0..15 give (n+1)*16 ms, codes 16..31 give n*48-464 ms
// - read-only read of diagnostic register clears restart cause
// - leaving sleep or fail-safe clears restart cause
// - restart cause codes: none, undervoltage, watchdog/cyclic wake, flash/external
// - three-bit fallback cause, back to 000 when fallback output switched off
// - fallback cause codes 001..110 name the activating failure, 111 reserved
// - three-bit readout of strap, test pin and fail-to-fallback setting
// - readout 000..011 report configurations 1 to 4
// - top readout bit means software development mode, watchdog failure harmless
// - non read-only commands get their data in the following frame
// - first frame in normal mode shows previous mode and a chosen register
// - showing bits in that first frame does not clear them
// - read-only clears the selected register's sticky bits except the fallback cause, not live state
// - read-only writes no register and changes no mode
// - read-only command counts as a watchdog trigger
// - read-only shifts out selected register within the same frame
// - select 111 is not writable; reads return the diagnostic fields
// - threshold selector lives in configuration register 100, default 01
`timescale 1ns/10ps
module sse_spi_status
   import sse_pkg::*;
(
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_srst,
   input  wire logic                 i_spi_clk,
   input  wire logic                 i_spi_csn,
   input  wire logic                 i_spi_sdi,
   input  wire logic                 i_strap_int_cfg,
   input  wire logic                 i_strap_test,
   input  wire logic [2:0]           i_cur_mode,
   input  wire logic                 i_enter_normal,
   input  wire logic [2:0]           i_prev_mode,
   input  wire logic                 i_restart_by_fail,
   input  wire logic                 i_leave_sleep_fs,
   input  wire logic                 i_restart_evt,
   input  wire logic [1:0]           i_restart_code,
   input  wire logic                 i_fallback_evt,
   input  wire logic [2:0]           i_fallback_code,
   input  wire logic [WAKE_BITS-1:0] i_wake_evt,
   input  wire logic [WAKE_BITS-1:0] i_wake_state,
   output logic                      o_spi_sdo,
   output logic                      o_spi_sdo_oe,
   output logic [1:0]                o_reset_level,
   output logic [10:0]               o_wdog_period_ms,
   output logic [4:0]                o_wdog_code,
   output logic                      o_fallback_on,
   output logic [1:0]                o_restart_cause,
   output logic [2:0]                o_fallback_cause,
   output logic [2:0]                o_strap_readout,
   output logic                      o_sw_dev_mode,
   output logic                      o_mode_cmd_vld,
   output logic [2:0]                o_mode_cmd,
   output logic                      o_wdog_trig
);

   // watchdog period in ms from the five-bit code
   function automatic logic [10:0] wdog_ms(input logic [4:0] code);
      logic [10:0] n;
      n = {6'h00, code};
      if (code < WDOG_CODE_SPLIT)
         wdog_ms = 11'((n + 11'h001) * WDOG_STEP_LO_MS);
      else
         wdog_ms = 11'((n * WDOG_STEP_HI_MS) - WDOG_OFFSET_MS);
   endfunction

   // synchronisers for the spi pins and straps
   logic [2:0]             clk_sync_reg;
   logic [1:0]             csn_sync_reg;
   logic [1:0]             sdi_sync_reg;
   logic [1:0]             strap_int_sync_reg;
   logic [1:0]             strap_test_sync_reg;

   logic [FRAME_BITS-1:0]  rx_reg;
   logic [4:0]             bit_cnt_reg;
   logic                   active_reg;
   logic [DATA_BITS-1:0]   regs_reg [REG_COUNT];
   logic [WAKE_BITS-1:0]   wake_flag_reg;
   logic [2:0]             resp_sel_reg;
   logic [2:0]             tx_sel_reg;
   logic [DATA_BITS-1:0]   resp_data_reg;
   logic [2:0]             resp_mode_reg;
   logic                   first_pend_reg;
   logic [2:0]             first_mode_reg;
   logic [2:0]             first_sel_reg;
   logic                   strap_done_reg;

   wire                    clk_rise   = clk_sync_reg[1] & ~clk_sync_reg[2];
   wire                    clk_fall   = ~clk_sync_reg[1] & clk_sync_reg[2];
   wire                    csn_low    = ~csn_sync_reg[1];
   wire                    frame_open = csn_low & ~active_reg;
   wire                    frame_end  = ~csn_low & active_reg;
   wire sse_frame_s        rx_frame   = rx_reg;
   wire                    frame_ok   = frame_end & (bit_cnt_reg == BIT_CNT_FULL);
   wire                    cmd_ro     = rx_frame.mode == MODE_READ_ONLY;
   wire                    ro_done    = frame_ok & cmd_ro;
   wire                    wr_done    = frame_ok & ~cmd_ro;
   wire [2:0]              cmd_sel    = rx_frame.cfg_sel;
   // writes go to every select except the diagnostic one
   wire                    wr_en      = wr_done & (cmd_sel != SEL_DIAG);
   wire                    wr_config  = wr_en & (cmd_sel == SEL_CONFIG);
   wire [1:0]              new_thresh = rx_frame.data[CFG_THRESH_LSB +: 2];
   wire                    fb_now     = regs_reg[SEL_CONFIG][CFG_FALLBACK_ON];
   wire                    fb_off_wr  = wr_config & fb_now & ~rx_frame.data[CFG_FALLBACK_ON];
   wire                    rd_diag    = ro_done & (cmd_sel == SEL_DIAG);
   wire                    rd_wake    = ro_done & (cmd_sel == SEL_WAKE);

   // readout of a register by select code
   function automatic logic [DATA_BITS-1:0] read_sel(input logic [2:0] sel);
      if (sel == SEL_DIAG)
         read_sel = {2'h0, o_strap_readout, o_fallback_cause, o_restart_cause};
      else if (sel == SEL_WAKE)
         read_sel = {i_wake_state, wake_flag_reg};
      else
         read_sel = regs_reg[sel];
   endfunction

   // outgoing frame; read-only takes its data from the select already shifted in
   wire                    ro_live    = (bit_cnt_reg >= 5'h03) & (rx_reg[2:0] == MODE_READ_ONLY);
   wire [DATA_BITS-1:0]    live_data  = read_sel(rx_reg[5:3]);
   sse_frame_s             tx_frame;
   assign tx_frame.mode    = resp_mode_reg;
   // the select shown is the one whose data this frame carries, first frame included; read-only frames show 000
   assign tx_frame.cfg_sel = ro_live ? 3'h0 : tx_sel_reg;
   assign tx_frame.data    = (ro_live && bit_cnt_reg >= BIT_IDX_DATA) ? live_data : resp_data_reg;
   wire [FRAME_BITS-1:0]   tx_word    = tx_frame;
   wire                    tx_bit     = (bit_cnt_reg < BIT_CNT_FULL) ? tx_word[bit_cnt_reg[3:0]] : 1'b0;

   // response source chosen at the start of a frame
   wire                    first_sel_src;
   assign first_sel_src    = first_pend_reg;
   wire [2:0]              open_sel   = first_sel_src ? first_sel_reg : resp_sel_reg;
   wire [2:0]              open_mode  = first_sel_src ? first_mode_reg : i_cur_mode;

   // first frame select from the previous mode
   wire [2:0]              entry_sel  = (i_prev_mode == PMODE_SLEEP)    ? SEL_WAKE :
                                        (i_prev_mode == PMODE_FAILSAFE) ? SEL_DIAG :
                                        (i_prev_mode == PMODE_RESTART && i_restart_by_fail) ? SEL_DIAG :
                                        SEL_CONFIG;

   wire [4:0]              wdog_code  = regs_reg[SEL_WDOG][WDOG_CODE_LSB +: 5];
   wire [2:0]              strap_val  = {strap_test_sync_reg[1], regs_reg[SEL_CONFIG][CFG_WD_TO_FB],
                                         strap_int_sync_reg[1]};

   always_ff @(posedge i_ref_clk)
   begin
      clk_sync_reg        <= {clk_sync_reg[1:0], i_spi_clk};
      csn_sync_reg        <= {csn_sync_reg[0], i_spi_csn};
      sdi_sync_reg        <= {sdi_sync_reg[0], i_spi_sdi};
      strap_int_sync_reg  <= {strap_int_sync_reg[0], i_strap_int_cfg};
      strap_test_sync_reg <= {strap_test_sync_reg[0], i_strap_test};
   end

   // spi shift engine
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         active_reg    <= 1'b0;
         bit_cnt_reg   <= 5'h00;
         rx_reg        <= '0;
         o_spi_sdo     <= 1'b0;
         o_spi_sdo_oe  <= 1'b0;
         resp_data_reg <= RST_OTHER;
         resp_mode_reg <= PMODE_INIT;
         tx_sel_reg    <= SEL_CONFIG;
      end
      else if (frame_open)
      begin
         active_reg    <= 1'b1;
         bit_cnt_reg   <= 5'h00;
         rx_reg        <= '0;
         resp_data_reg <= read_sel(open_sel);
         resp_mode_reg <= open_mode;
         tx_sel_reg    <= open_sel;
         o_spi_sdo     <= open_mode[0];
         o_spi_sdo_oe  <= 1'b1;
      end
      else if (frame_end)
      begin
         active_reg    <= 1'b0;
         o_spi_sdo     <= 1'b0;
         o_spi_sdo_oe  <= 1'b0;
      end
      else if (active_reg && clk_rise)
      begin
         if (bit_cnt_reg < BIT_CNT_FULL)
         begin
            rx_reg[bit_cnt_reg[3:0]] <= sdi_sync_reg[1];
            bit_cnt_reg              <= bit_cnt_reg + 5'h01;
         end
      end
      else if (active_reg && clk_fall)
      begin
         o_spi_sdo <= tx_bit;
      end
   end

   // register file; read-only and diagnostic selects are never written
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regs_reg[i] <= RST_OTHER;
         regs_reg[SEL_CONFIG] <= RST_CONFIG;
         regs_reg[SEL_WDOG]   <= RST_WDOG;
      end
      else if (wr_en)
      begin
         regs_reg[cmd_sel] <= rx_frame.data;
         if (wr_config && new_thresh == THRESH_INVALID)
            regs_reg[SEL_CONFIG][CFG_THRESH_LSB +: 2] <= regs_reg[SEL_CONFIG][CFG_THRESH_LSB +: 2];
      end
   end

   // response bookkeeping and first-frame selection
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         resp_sel_reg   <= SEL_CONFIG;
         first_pend_reg <= 1'b0;
         first_mode_reg <= PMODE_INIT;
         first_sel_reg  <= SEL_CONFIG;
      end
      else
      begin
         if (frame_ok)
            resp_sel_reg <= cmd_sel;
         if (i_enter_normal)
         begin
            first_pend_reg <= 1'b1;
            first_mode_reg <= i_prev_mode;
            first_sel_reg  <= entry_sel;
         end
         else if (frame_open)
            first_pend_reg <= 1'b0;
      end
   end

   // sticky diagnostic and wake fields; a set in the clear cycle wins
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_restart_cause  <= RST_RESTART;
         o_fallback_cause <= RST_FALLBACK;
         wake_flag_reg    <= '0;
      end
      else
      begin
         if (i_restart_evt)
            o_restart_cause <= i_restart_code;
         else if (rd_diag || i_leave_sleep_fs)
            o_restart_cause <= RST_RESTART;
         if (i_fallback_evt)
            o_fallback_cause <= i_fallback_code;
         else if (fb_off_wr)
            o_fallback_cause <= RST_FALLBACK;
         // only the sticky half is cleared, live state is read straight through
         wake_flag_reg <= (rd_wake ? '0 : wake_flag_reg) | i_wake_evt;
      end
   end

   // decoded controls
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_reset_level    <= THRESH_LEVEL_ONE;
         o_wdog_code      <= RST_WDOG[4:0];
         o_wdog_period_ms <= wdog_ms(RST_WDOG[4:0]);
         o_fallback_on    <= 1'b0;
         o_mode_cmd_vld   <= 1'b0;
         o_mode_cmd       <= PMODE_INIT;
         o_wdog_trig      <= 1'b0;
      end
      else
      begin
         if (regs_reg[SEL_CONFIG][CFG_THRESH_LSB +: 2] != THRESH_INVALID)
            o_reset_level <= regs_reg[SEL_CONFIG][CFG_THRESH_LSB +: 2];
         o_wdog_code      <= wdog_code;
         o_wdog_period_ms <= wdog_ms(wdog_code);
         o_fallback_on    <= fb_now;
         o_mode_cmd_vld   <= wr_done;
         if (wr_done)
            o_mode_cmd <= rx_frame.mode;
         o_wdog_trig      <= frame_ok;
      end
   end

   // straps are caught once, after reset release, once synchronised
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         strap_done_reg  <= 1'b0;
         o_strap_readout <= 3'h0;
         o_sw_dev_mode   <= 1'b0;
      end
      else
      begin
         if (!strap_done_reg)
         begin
            strap_done_reg <= 1'b1;
            o_strap_readout[2] <= strap_val[2];
            o_strap_readout[0] <= strap_val[0];
         end
         o_strap_readout[1] <= strap_val[1];
         if (!strap_done_reg)
            o_sw_dev_mode <= strap_val[2];
      end
   end

endmodule // sse_spi_status

// ---- hdl/sse_pkg.sv ----
// package of constants and frame types for the spi status encoder block
package sse_pkg;
   localparam int         FRAME_BITS      = 16;
   localparam int         DATA_BITS       = 10;
   localparam int         REG_COUNT       = 8;
   localparam logic [4:0] BIT_CNT_FULL    = 5'h10;
   localparam logic [4:0] BIT_IDX_DATA    = 5'h06;
   // mode select command codes
   localparam logic [2:0] MODE_READ_ONLY  = 3'h7;
   // configuration select codes
   localparam logic [2:0] SEL_WAKE        = 3'h0;
   localparam logic [2:0] SEL_CONFIG      = 3'h4;
   localparam logic [2:0] SEL_WDOG        = 3'h6;
   localparam logic [2:0] SEL_DIAG        = 3'h7;
   // previous-mode codes shown in the first frame
   localparam logic [2:0] PMODE_INIT      = 3'h0;
   localparam logic [2:0] PMODE_RESTART   = 3'h1;
   localparam logic [2:0] PMODE_SLEEP     = 3'h2;
   localparam logic [2:0] PMODE_FAILSAFE  = 3'h3;
   // configuration register fields
   localparam int         CFG_THRESH_LSB  = 0;
   localparam int         CFG_FALLBACK_ON = 6;
   localparam int         CFG_WD_TO_FB    = 8;
   localparam logic [1:0] THRESH_INVALID  = 2'h0;
   localparam logic [1:0] THRESH_LEVEL_ONE = 2'h1;
   // watchdog register field
   localparam int         WDOG_CODE_LSB   = 0;
   localparam logic [4:0] WDOG_CODE_SPLIT = 5'h10;
   localparam logic [10:0] WDOG_STEP_LO_MS = 11'h010;
   localparam logic [10:0] WDOG_STEP_HI_MS = 11'h030;
   localparam logic [10:0] WDOG_OFFSET_MS  = 11'h1D0;
   // reset values
   localparam logic [9:0] RST_CONFIG      = 10'h115;
   localparam logic [9:0] RST_WDOG        = 10'h1EF;
   localparam logic [9:0] RST_OTHER       = 10'h000;
   localparam logic [1:0] RST_RESTART     = 2'h0;
   localparam logic [2:0] RST_FALLBACK    = 3'h0;
   localparam int         WAKE_BITS       = 5;

   typedef struct packed {
      logic [9:0] data;
      logic [2:0] cfg_sel;
      logic [2:0] mode;
   } sse_frame_s;

   typedef struct packed {
      logic       sw_dev_mode;
      logic       two_fail;
      logic       supply_off;
   } sse_strap_s;
endpackage

// ---- sim/sse_spi_mst.sv ----
// spi master model that drives frames into the status encoder
`timescale 1ns/10ps
module sse_spi_mst
   import sse_pkg::*;
(
   input  wire logic i_ref_clk,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe,
   output logic      o_sclk,
   output logic      o_csn,
   output logic      o_sdi
);
   logic last_reg = 1'b0;
   // a released sdo line shows the inverse of its last bit
   wire  logic sdo_line = i_sdo_oe ? i_sdo : ~last_reg;
   initial
   begin
      o_sclk = 1'b0;
      o_csn  = 1'b1;
      o_sdi  = 1'b0;
   end
   // n bits lsb first, clock still outside frames, pull-down level on sdi after
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx    = 16'h0000;
      o_csn = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      for (int k = 0; k < n; k++)
      begin
         o_sdi = tx[k];
         repeat (4) @(negedge i_ref_clk);
         rx[k]    = sdo_line;
         last_reg = sdo_line;
         o_sclk   = 1'b1;
         repeat (4) @(negedge i_ref_clk);
         o_sclk   = 1'b0;
      end
      repeat (4) @(negedge i_ref_clk);
      o_csn = 1'b1;
      o_sdi = 1'b0;
      repeat (12) @(negedge i_ref_clk);
   endtask
endmodule // sse_spi_mst

// ---- sim/sse_spi_status_properties.sv ----
// port checks for the spi status encoder
`timescale 1ns/10ps
module sse_spi_status_chk
   import sse_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   input wire logic        i_restart_evt,
   input wire logic        i_leave_sleep_fs,
   input wire logic [1:0]  o_reset_level,
   input wire logic [10:0] o_wdog_period_ms,
   input wire logic [4:0]  o_wdog_code,
   input wire logic [1:0]  o_restart_cause,
   input wire logic [2:0]  o_strap_readout,
   input wire logic        o_mode_cmd_vld,
   input wire logic [2:0]  o_mode_cmd,
   input wire logic        o_wdog_trig
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   wire logic [10:0] code_ext = {6'h00, o_wdog_code};
   wire logic [10:0] exp_ms   = (o_wdog_code < 5'h10) ? (code_ext + 11'h001) * 11'h010
                                                      : code_ext * 11'h030 - 11'h1D0;
   thresh_valid_a: assert property (o_reset_level != 2'h0)
      else $error("reset level shows code 00");
   wdog_map_a: assert property ($stable(o_wdog_code) |-> o_wdog_period_ms == exp_ms)
      else $error("watchdog period does not match code");
   restart_clr_a: assert property (i_leave_sleep_fs && !i_restart_evt |-> ##[1:2] o_restart_cause == 2'h0)
      else $error("restart cause kept after leaving sleep");
   strap_hold_a: assert property (!$past(i_srst) && !$past(i_srst, 2) |-> $stable(o_strap_readout[2]))
      else $error("test strap readout changed");
   ro_no_cmd_a: assert property (o_mode_cmd_vld |-> o_mode_cmd != MODE_READ_ONLY)
      else $error("read-only frame issued a mode command");
   cmd_trig_a: assert property (o_mode_cmd_vld |-> o_wdog_trig)
      else $error("command frame without trigger");
   trig_pulse_a: assert property (o_wdog_trig |=> !o_wdog_trig)
      else $error("trigger longer than one cycle");
   ro_keep_a: assert property (o_wdog_trig && !o_mode_cmd_vld |-> ($stable(o_reset_level) && $stable(o_wdog_code)) [*3])
      else $error("read-only frame changed settings");
   ro_seen_c: cover property (o_wdog_trig && !o_mode_cmd_vld);
   leave_seen_c: cover property (i_leave_sleep_fs);
   level_seen_c: cover property ($changed(o_reset_level));
endmodule // sse_spi_status_chk

bind sse_spi_status sse_spi_status_chk u_chk (.i_ref_clk, .i_srst, .i_restart_evt, .i_leave_sleep_fs, .o_reset_level,
   .o_wdog_period_ms, .o_wdog_code, .o_restart_cause, .o_strap_readout, .o_mode_cmd_vld, .o_mode_cmd, .o_wdog_trig);

// ---- sim/sse_spi_status_tb_top.sv ----
// self-checking bench for the spi status encoder
`timescale 1ns/10ps
module sse_spi_status_tb_top
   import sse_pkg::*;
;
   logic i_ref_clk, i_spi_clk, i_spi_csn, i_spi_sdi, o_spi_sdo, o_spi_sdo_oe, o_fallback_on, o_sw_dev_mode;
   logic o_mode_cmd_vld, o_wdog_trig, i_srst = 1'b1, i_strap_int_cfg = 1'b0, i_strap_test = 1'b0;
   logic i_enter_normal = 1'b0, i_restart_by_fail = 1'b0, i_leave_sleep_fs = 1'b0, i_restart_evt = 1'b0;
   logic i_fallback_evt = 1'b0;
   logic [2:0] i_cur_mode = 3'h5, i_prev_mode = 3'h0, i_fallback_code = 3'h0;
   logic [2:0] o_fallback_cause, o_strap_readout, o_mode_cmd;
   logic [1:0] i_restart_code = 2'h0, o_reset_level, o_restart_cause;
   logic [WAKE_BITS-1:0] i_wake_evt = 5'h00, i_wake_state = 5'h0A;
   logic [10:0] o_wdog_period_ms;
   logic [4:0]  o_wdog_code;
   sse_frame_s  rx;
   int mismatches = 0, checks_done = 0, cycles = 0;

   sse_spi_status dut (.i_ref_clk, .i_srst, .i_spi_clk, .i_spi_csn, .i_spi_sdi, .i_strap_int_cfg, .i_strap_test,
      .i_cur_mode, .i_enter_normal, .i_prev_mode, .i_restart_by_fail, .i_leave_sleep_fs, .i_restart_evt,
      .i_restart_code, .i_fallback_evt, .i_fallback_code, .i_wake_evt, .i_wake_state, .o_spi_sdo, .o_spi_sdo_oe,
      .o_reset_level, .o_wdog_period_ms, .o_wdog_code, .o_fallback_on, .o_restart_cause, .o_fallback_cause,
      .o_strap_readout, .o_sw_dev_mode, .o_mode_cmd_vld, .o_mode_cmd, .o_wdog_trig);
   sse_spi_mst u_mst (.i_ref_clk, .i_sdo(o_spi_sdo), .i_sdo_oe(o_spi_sdo_oe), .o_sclk(i_spi_clk),
      .o_csn(i_spi_csn), .o_sdi(i_spi_sdi));

   task automatic tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(3);
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [9:0] d);
      u_mst.xfer({d, s, 3'h3}, 16, rx);
   endtask
   task automatic ro(input logic [2:0] s);
      u_mst.xfer({10'h000, s, MODE_READ_ONLY}, 16, rx);
   endtask
   task automatic t_straps();
      for (int i = 0; i < 4; i++)
      begin
         i_strap_test    = i[1];
         i_strap_int_cfg = i[0];
         i_srst = 1'b1;
         tick(16);
         i_srst = 1'b0;
         tick(4);
         if (i == 0) check("lvl_rst", 16'(o_reset_level), 16'h0001);
         if (i == 0) check("wd_rst", 16'({o_wdog_code, o_wdog_period_ms}), 16'({5'h0F, 11'h100}));
         ro(SEL_DIAG);
         check("strap_rd", 16'(rx.data[7:5]), 16'({i[1], 1'b1, i[0]}));
         check("dev_mode", 16'(o_sw_dev_mode), 16'(i[1]));
         wr(SEL_CONFIG, 10'h015);
         check("strap_cfg", 16'(o_strap_readout), 16'({i[1], 1'b0, i[0]}));
      end
   endtask
   task automatic t_thresh();
      logic [1:0] codes [5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h0};
      logic [1:0] exp = 2'h1;
      for (int i = 0; i < 5; i++)
      begin
         wr(SEL_CONFIG, 10'h114 | 10'(codes[i]));
         if (codes[i] != 2'h0) exp = codes[i];
         check("thresh", 16'(o_reset_level), 16'(exp));
      end
   endtask
   task automatic t_wdog();
      for (int n = 0; n < 32; n++)
      begin
         wr(SEL_WDOG, 10'h1E0 | 10'(n));
         check("wd_ms", 16'(o_wdog_period_ms), 16'((n < 16) ? (n + 1) * 16 : n * 48 - 464));
         check("wd_code", 16'(o_wdog_code), 16'(n));
         if (n > 0) check("prev", 16'(rx.data), 16'(10'h1E0 | 10'(n - 1)));
         check("cur_mode", 16'(rx.mode), 16'h0005);
      end
   endtask
   task automatic t_restart();
      for (int c = 1; c < 4; c++)
      begin
         i_restart_code = 2'(c);
         pulse(i_restart_evt);
         check("rst_cause", 16'(o_restart_cause), 16'(c));
         ro(SEL_DIAG);
         check("ro_sel", 16'({rx.cfg_sel, rx.data[1:0]}), 16'(c));
         check("ro_clr", 16'(o_restart_cause), 16'h0000);
      end
      pulse(i_restart_evt);
      pulse(i_leave_sleep_fs);
      check("leave_clr", 16'(o_restart_cause), 16'h0000);
   endtask
   task automatic t_fallback();
      wr(SEL_CONFIG, 10'h155);
      check("fb_on", 16'(o_fallback_on), 16'h0001);
      for (int c = 1; c < 8; c++)
      begin
         i_fallback_code = 3'(c);
         pulse(i_fallback_evt);
         check("fb_cause", 16'(o_fallback_cause), 16'(c));
      end
      wr(SEL_DIAG, 10'h3FF);
      check("diag_wr", 16'(o_fallback_cause), 16'h0007);
      wr(SEL_CONFIG, 10'h115);
      check("fb_clr", 16'(o_fallback_cause), 16'h0000);
   endtask
   task automatic t_first();
      logic [2:0] pm [4] = '{PMODE_SLEEP, PMODE_FAILSAFE, PMODE_RESTART, PMODE_INIT};
      logic [2:0] sl [4] = '{SEL_WAKE, SEL_DIAG, SEL_DIAG, SEL_CONFIG};
      i_wake_evt = 5'h15;
      tick(1);
      i_wake_evt = 5'h00;
      for (int i = 0; i < 4; i++)
      begin
         i_prev_mode       = pm[i];
         i_restart_by_fail = (i == 2);
         pulse(i_enter_normal);
         wr(3'h1, 10'h000);
         check("first", 16'({rx.cfg_sel, rx.mode}), 16'({sl[i], pm[i]}));
      end
      ro(SEL_WAKE);
      check("wake_kept", 16'(rx.data), 16'h0155);
      ro(SEL_WAKE);
      check("wake_clr", 16'(rx.data), 16'h0140);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   // hang guard: about three times the expected run
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         conclude();
      end
   end
   initial
   begin
      t_straps();
      t_thresh();
      t_wdog();
      t_restart();
      t_fallback();
      t_first();
      conclude();
   end
endmodule // sse_spi_status_tb_top
